// File: ssb_serial_consts.vh
// Constants for the serial status and bit rate block.
`ifndef SSB_SERIAL_CONSTS_VH
`define SSB_SERIAL_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SSB_OFS_STATUS    8'h00
`define SSB_OFS_DIVISOR   8'h04
`define SSB_OFS_MODE      8'h08
`define SSB_OFS_CONTROL   8'h0C
`define SSB_OFS_TXHOLD    8'h10
`define SSB_OFS_RXHOLD    8'h14
`define SSB_OFS_INTSTAT   8'h18
`define SSB_OFS_INTEN     8'h1C
`define SSB_OFS_INTCLR    8'h20
// ****************************************
// Status register fields
// ****************************************
`define SSB_ST_TXE        7
`define SSB_ST_RXF        6
`define SSB_ST_PER        3
`define SSB_ST_TRANSMIT_DONE_FLAG       2
`define SSB_ST_MPB        1
`define SSB_ST_MULTIPROC_BIT_TO_SEND       0
// ****************************************
// Mode and control register fields
// ****************************************
`define SSB_MD_CKS_LO     0
`define SSB_MD_CKS_HI     1
`define SSB_MD_ODD        2
`define SSB_MD_PAR_EN     3
`define SSB_MD_MP_FMT     4
`define SSB_MD_SYNC       5
`define SSB_CT_RX_ON      0
`define SSB_CT_TX_ON      1
// ****************************************
// Interrupt event bits
// ****************************************
`define SSB_EV_PER        0
`define SSB_EV_TRANSMIT_DONE_FLAG       1
`define SSB_EV_RXF        2
`define SSB_EV_TXE        3
`define SSB_EV_W          4
// ****************************************
// Reset values and prescaler taps
// ****************************************
`define SSB_DIV_RST       8'hFF
`define SSB_MODE_RST      6'h00
`define SSB_CTRL_RST      2'h0
`define SSB_PRE_W         6
`define SSB_PRE_DIV4      6'h03
`define SSB_PRE_DIV16     6'h0F
`define SSB_PRE_DIV64     6'h3F
`endif

// File: ssb_serial_status.v
// Status flags, multiprocessor bits and bit rate generator of one serial channel.
`timescale 1ns/1ns
`default_nettype none
`include "ssb_serial_consts.vh"

// Summary of operation
// - Parity error flag clears on reset, standby, or zero write after reading it set.
// - Parity error flag sets when received ones count disagrees with selected parity.
// - Turning the receiver off leaves the parity error flag as it was.
// - A parity-errored character still lands in rx_holding, without setting full.
// - Parity error blocks reception, and in synchronous mode transmission too.
// - Transmit done flag is read only; writes to its bit do nothing.
// - Transmit done clears on software clear of empty flag or dma tx write.
// - Transmit done sets on reset, standby, tx_on low, or last bit while empty.
// - Async multiprocessor reception stores the received multiprocessor bit, read only.
// - Turning the receiver off keeps the stored multiprocessor bit.
// - Async multiprocessor transmission appends the multiproc_bit_to_send value; resets to zero.
// - multiproc_bit_to_send is ignored in sync mode, non-mp format, or idle.
// - Bit rate comes from the 8-bit divisor and the two-bit clock source select.
// - Divisor is always read-writable and loads all ones on reset and standby.
// - Each channel has its own divisor and generator, one instance per channel.
// - Status flags accept only zero writes, clearing only after being read set.
module ssb_serial_status (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        standby,
    input  wire        rx_char_done,
    input  wire [7:0]  rx_char_data,
    input  wire        rx_char_parity,
    input  wire        rx_char_mpb,
    input  wire        tx_load,
    input  wire        tx_last_bit,
    input  wire        tx_busy,
    input  wire        dma_tx_write,
    input  wire [7:0]  dma_tx_data,
    input  wire        dma_rx_read,
    output wire [7:0]  tx_holding,
    output wire        tx_mpb_out,
    output wire        rx_block,
    output wire        tx_block,
    output wire        baud_tick,
    output wire        irq
);
    // ****************************************
    // Register state
    // ****************************************
    reg  [7:0]           div_q;
    reg  [5:0]           mode_q;
    reg  [1:0]           ctrl_q;
    reg  [7:0]           txh_q;
    reg  [7:0]           rxh_q;
    reg                  txe_q;
    reg                  rxf_q;
    reg                  per_q;
    reg                  transmit_done_flag_q;
    reg                  mpb_q;
    reg                  multiproc_bit_to_send_q;
    reg                  txe_arm_q;
    reg                  rxf_arm_q;
    reg                  per_arm_q;
    reg  [`SSB_EV_W-1:0] ist_q;
    reg  [`SSB_EV_W-1:0] ien_q;
    reg  [`SSB_PRE_W-1:0] pre_q;
    reg  [7:0]           cnt_q;
    reg                  tick_q;
    reg  [`SSB_EV_W-1:0] ev;
    reg                  hit;
    reg  [31:0]          rd_d;

    wire        wr_acc   = psel & penable & pwrite;
    wire        rd_acc   = psel & penable & ~pwrite;
    wire        rd_setup = psel & ~penable & ~pwrite;
    wire        is_sync  = mode_q[`SSB_MD_SYNC];
    wire        mp_fmt   = mode_q[`SSB_MD_MP_FMT] & ~is_sync;
    wire        rx_on    = ctrl_q[`SSB_CT_RX_ON];
    wire        tx_on    = ctrl_q[`SSB_CT_TX_ON];
    wire        wr_st    = wr_acc & (paddr == `SSB_OFS_STATUS);
    wire [7:0]  status   = {txe_q, rxf_q, 2'h0, per_q, transmit_done_flag_q, mpb_q, multiproc_bit_to_send_q};

    // ****************************************
    // Register decode
    // ****************************************
    // Every register is one aligned word; unmapped offsets read zero with an error.
    wire        wr_div   = wr_acc & (paddr == `SSB_OFS_DIVISOR);
    wire        wr_mode  = wr_acc & (paddr == `SSB_OFS_MODE);
    wire        wr_ctrl  = wr_acc & (paddr == `SSB_OFS_CONTROL);
    wire        wr_ien   = wr_acc & (paddr == `SSB_OFS_INTEN);
    wire        wr_iclr  = wr_acc & (paddr == `SSB_OFS_INTCLR);
    wire        rd_st    = rd_acc & (paddr == `SSB_OFS_STATUS);

    // ****************************************
    // Receive acceptance and parity check
    // ****************************************
    // A blocked receiver drops the character: the engine is told via rx_block.
    wire rx_take  = rx_char_done & rx_on & ~per_q;
    wire par_bad  = mode_q[`SSB_MD_PAR_EN] & ~is_sync &
                    ((^rx_char_data ^ rx_char_parity) != mode_q[`SSB_MD_ODD]);
    wire per_set  = rx_take & par_bad;
    wire rxf_set  = rx_take & ~par_bad;
    wire per_clr  = wr_st & per_arm_q & ~pwdata[`SSB_ST_PER];
    wire rxf_clr  = (wr_st & rxf_arm_q & ~pwdata[`SSB_ST_RXF]) | dma_rx_read;
    wire cpu_txw  = wr_acc & (paddr == `SSB_OFS_TXHOLD);
    wire txe_swc  = wr_st & txe_arm_q & ~pwdata[`SSB_ST_TXE];
    wire txe_set  = tx_load | ~tx_on;
    wire txe_clr  = txe_swc | dma_tx_write;
    wire transmit_done_flag_set = ~tx_on | (tx_last_bit & txe_q);
    wire transmit_done_flag_clr = txe_swc | dma_tx_write;

    assign rx_block   = per_q;
    assign tx_block   = per_q & is_sync;
    assign tx_mpb_out = multiproc_bit_to_send_q & mp_fmt & tx_busy & tx_on;
    assign tx_holding = txh_q;

    // ****************************************
    // Status flags
    // ****************************************
    // Standby acts as a synchronous copy of the reset for every flag.
    // Each flag tests its set term first, so a same-cycle clear loses.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            per_q <= 1'b0;
        else if (standby)
            per_q <= 1'b0;
        else if (per_set)
            per_q <= 1'b1;
        else if (per_clr)
            per_q <= 1'b0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rxf_q <= 1'b0;
        else if (standby)
            rxf_q <= 1'b0;
        else if (rxf_set)
            rxf_q <= 1'b1;
        else if (rxf_clr)
            rxf_q <= 1'b0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txe_q <= 1'b1;
        else if (standby)
            txe_q <= 1'b1;
        else if (txe_set)
            txe_q <= 1'b1;
        else if (txe_clr)
            txe_q <= 1'b0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            transmit_done_flag_q <= 1'b1;
        else if (standby)
            transmit_done_flag_q <= 1'b1;
        else if (transmit_done_flag_set)
            transmit_done_flag_q <= 1'b1;
        else if (transmit_done_flag_clr)
            transmit_done_flag_q <= 1'b0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mpb_q <= 1'b0;
        else if (standby)
            mpb_q <= 1'b0;
        else if (rx_take & mp_fmt)
            mpb_q <= rx_char_mpb;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rxh_q <= 8'h00;
        else if (standby)
            rxh_q <= 8'h00;
        else if (rx_take)
            rxh_q <= rx_char_data;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txh_q <= 8'h00;
        else if (standby)
            txh_q <= 8'h00;
        else if (dma_tx_write)
            txh_q <= dma_tx_data;
        else if (cpu_txw)
            txh_q <= pwdata[7:0];
    end

    // ****************************************
    // Read-then-clear arming
    // ****************************************
    // A flag is armed only by a read that saw it set; any status write disarms.
    // Arming follows the captured read data, so a flag that sets between setup
    // and access cannot be cleared by software that never saw it set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            per_arm_q <= 1'b0;
        else if (standby | wr_st)
            per_arm_q <= 1'b0;
        else if (rd_st)
            per_arm_q <= prdata[`SSB_ST_PER];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rxf_arm_q <= 1'b0;
        else if (standby | wr_st)
            rxf_arm_q <= 1'b0;
        else if (rd_st)
            rxf_arm_q <= prdata[`SSB_ST_RXF];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txe_arm_q <= 1'b0;
        else if (standby | wr_st)
            txe_arm_q <= 1'b0;
        else if (rd_st)
            txe_arm_q <= prdata[`SSB_ST_TXE];
    end

    // ****************************************
    // Software registers
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_q <= `SSB_DIV_RST;
        else if (standby)
            div_q <= `SSB_DIV_RST;
        else if (wr_div)
            div_q <= pwdata[7:0];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_q <= `SSB_MODE_RST;
        else if (standby)
            mode_q <= `SSB_MODE_RST;
        else if (wr_mode)
            mode_q <= pwdata[5:0];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= `SSB_CTRL_RST;
        else if (standby)
            ctrl_q <= `SSB_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= pwdata[1:0];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            multiproc_bit_to_send_q <= 1'b0;
        else if (standby)
            multiproc_bit_to_send_q <= 1'b0;
        else if (wr_st)
            multiproc_bit_to_send_q <= pwdata[`SSB_ST_MULTIPROC_BIT_TO_SEND];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ien_q <= {`SSB_EV_W{1'b0}};
        else if (standby)
            ien_q <= {`SSB_EV_W{1'b0}};
        else if (wr_ien)
            ien_q <= pwdata[`SSB_EV_W-1:0];
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    // Clear by writing one; an event in the clear cycle keeps its bit set.
    genvar g;
    generate
        for (g = 0; g < `SSB_EV_W; g = g + 1) begin : g_ist
            always @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    ist_q[g] <= 1'b0;
                else if (standby)
                    ist_q[g] <= 1'b0;
                else if (ev[g])
                    ist_q[g] <= 1'b1;
                else if (wr_iclr & pwdata[g])
                    ist_q[g] <= 1'b0;
            end
        end
    endgenerate

    always @* begin
        ev = {`SSB_EV_W{1'b0}};
        ev[`SSB_EV_PER]  = per_set;
        ev[`SSB_EV_TRANSMIT_DONE_FLAG] = tx_last_bit & txe_q;
        ev[`SSB_EV_RXF]  = rxf_set;
        ev[`SSB_EV_TXE]  = tx_load;
    end

    assign irq = |(ist_q & ien_q);

    // ****************************************
    // Baud rate generator
    // ****************************************
    // The prescaler picks the input clock, the divisor counts N+1 of its ticks.
    reg  [`SSB_PRE_W-1:0] pre_top;
    always @* begin
        case ({mode_q[`SSB_MD_CKS_HI], mode_q[`SSB_MD_CKS_LO]})
            2'h0:    pre_top = {`SSB_PRE_W{1'b0}};
            2'h1:    pre_top = `SSB_PRE_DIV4;
            2'h2:    pre_top = `SSB_PRE_DIV16;
            default: pre_top = `SSB_PRE_DIV64;
        endcase
    end
    wire pre_tick = (pre_q >= pre_top);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q  <= {`SSB_PRE_W{1'b0}};
            cnt_q  <= `SSB_DIV_RST;
            tick_q <= 1'b0;
        end else if (standby | ~(tx_on | rx_on)) begin
            pre_q  <= {`SSB_PRE_W{1'b0}};
            cnt_q  <= div_q;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_tick ? {`SSB_PRE_W{1'b0}} : pre_q + 1'b1;
            tick_q <= pre_tick & (cnt_q == 8'h00);
            if (pre_tick)
                cnt_q <= (cnt_q == 8'h00) ? div_q : cnt_q - 8'h01;
        end
    end
    assign baud_tick = tick_q;

    // ****************************************
    // APB slave
    // ****************************************
    // Read data is captured in the setup phase so it leaves a flip-flop.
    always @* begin
        hit  = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            `SSB_OFS_STATUS:  rd_d[7:0] = status;
            `SSB_OFS_DIVISOR: rd_d[7:0] = div_q;
            `SSB_OFS_MODE:    rd_d[5:0] = mode_q;
            `SSB_OFS_CONTROL: rd_d[1:0] = ctrl_q;
            `SSB_OFS_TXHOLD:  rd_d[7:0] = txh_q;
            `SSB_OFS_RXHOLD:  rd_d[7:0] = rxh_q;
            `SSB_OFS_INTSTAT: rd_d[`SSB_EV_W-1:0] = ist_q;
            `SSB_OFS_INTEN:   rd_d[`SSB_EV_W-1:0] = ien_q;
            `SSB_OFS_INTCLR:  rd_d = 32'h0000_0000;
            default:          hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= rd_d;
    end

    // No wait states: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

endmodule // ssb_serial_status
`default_nettype wire

// File: ssb_serial_partner.sv
// Remote serial partner model that presents received characters to the block.
`timescale 1ns/1ns
`default_nettype none
module ssb_serial_partner (
    input  wire logic       pclk,
    output var  logic       done,
    output var  logic [7:0] data,
    output var  logic       par,
    output var  logic       multiproc_bit_received
);
    initial begin
        done = 1'b0;
        data = 8'hA5;
        par  = 1'b0;
        multiproc_bit_received  = 1'b0;
    end
    // Outside a character the lines show the inverse, so stale values never look valid.
    task automatic send(input logic [7:0] d, input logic odd, input logic bad, input logic m);
        @(posedge pclk);
        done <= 1'b1;
        data <= d;
        par  <= ^d ^ odd ^ bad;
        multiproc_bit_received  <= m;
        @(posedge pclk);
        done <= 1'b0;
        data <= ~d;
        par  <= ~(^d ^ odd ^ bad);
        multiproc_bit_received  <= ~m;
    endtask
endmodule // ssb_serial_partner
`default_nettype wire

// File: ssb_serial_status_props.sv
// Concurrent checks on the ports of the serial status block.
`timescale 1ns/1ns
`default_nettype none
`include "ssb_serial_consts.vh"
module ssb_serial_status_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       standby,
    input wire logic       rx_char_done,
    input wire logic       tx_busy,
    input wire logic       rx_block,
    input wire logic       tx_block,
    input wire logic       tx_mpb_out,
    input wire logic       baud_tick,
    input wire logic       irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_apb_no_wait: assert property (psel && penable |-> pready)
        else $error("Access phase without ready.");
    chk_tx_block_cause: assert property (tx_block |-> rx_block)
        else $error("Transmit blocked without a parity error.");
    chk_per_set_cause: assert property ($rose(rx_block) |-> $past(rx_char_done))
        else $error("Parity error flag set without a character.");
    chk_per_hold: assert property (rx_block && !standby && !(psel && penable && pwrite &&
        paddr == `SSB_OFS_STATUS) |=> rx_block) else $error("Parity error flag dropped.");
    chk_per_release: assert property ($fell(rx_block) |-> $past(standby) || $past(psel && pwrite))
        else $error("Parity error flag cleared without cause.");
    chk_mpb_out_busy: assert property (tx_mpb_out |-> tx_busy)
        else $error("Multiprocessor bit sent while idle.");
    chk_standby_clear: assert property (standby |=> !rx_block && !irq)
        else $error("Standby did not clear flags.");
    chk_baud_idle: assert property (standby [*2] |=> !baud_tick)
        else $error("Bit rate tick during standby.");
endmodule // ssb_serial_status_props
bind ssb_serial_status ssb_serial_status_props ssb_serial_status_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .standby(standby),
    .rx_char_done(rx_char_done), .tx_busy(tx_busy), .rx_block(rx_block), .tx_block(tx_block),
    .tx_mpb_out(tx_mpb_out), .baud_tick(baud_tick), .irq(irq));
`default_nettype wire

// File: ssb_serial_status_tb.sv
// Self-checking testbench for the serial status block.
`timescale 1ns/1ns
`default_nettype none
`include "ssb_serial_consts.vh"
module ssb_serial_status_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
    logic        tx_load = 1'b0, tx_last_bit = 1'b0, tx_busy = 1'b0, dma_tx_write = 1'b0, dma_rx_read = 1'b0;
    logic [7:0]  paddr = 8'h00, dma_tx_data = 8'h00, rxd, txh, d;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rxdone, rxpar, rxmpb, txmpb, rxb, txb, tick, irq;
    logic [32:0] expq[$];
    int          fails = 0, comparisons = 0, n;
    integer      seed = 32'h97213702;
    always #2 pclk = ~pclk;
    ssb_serial_partner ssb_serial_partner_i (.pclk(pclk), .done(rxdone), .data(rxd), .par(rxpar), .multiproc_bit_received(rxmpb));
    ssb_serial_status ssb_serial_status_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .standby(standby), .rx_char_done(rxdone), .rx_char_data(rxd), .rx_char_parity(rxpar),
        .rx_char_mpb(rxmpb), .tx_load(tx_load), .tx_last_bit(tx_last_bit), .tx_busy(tx_busy),
        .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read),
        .tx_holding(txh), .tx_mpb_out(txmpb), .rx_block(rxb), .tx_block(txb), .baud_tick(tick), .irq(irq));
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task check(input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // ****************************************
    // Register bus master
    // ****************************************
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        if (!w) expq.push_back(e);
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin fails++; finish_test; end
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] wd); apb(1'b1, a, wd, 33'h0); endtask
    task rd(input logic [7:0] a, input logic [32:0] e); apb(1'b0, a, 32'h0, e); endtask
    // The read monitor takes the oldest expectation whenever a read access completes.
    always @(posedge pclk) if (psel && penable && pready && !pwrite) check(expq.pop_front(), {pslverr, prdata});
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SSB_OFS_STATUS, 33'h84);
        rd(`SSB_OFS_DIVISOR, 33'hFF);
        d = $random(seed);
        wr(`SSB_OFS_DIVISOR, {24'h0, d}); rd(`SSB_OFS_DIVISOR, {25'h0, d});
        wr(`SSB_OFS_STATUS, 32'hFF); rd(`SSB_OFS_STATUS, 33'h85);
        rd(8'h24, 33'h1_0000_0000);
        wr(`SSB_OFS_INTEN, 32'h01); wr(`SSB_OFS_MODE, 32'h18); wr(`SSB_OFS_CONTROL, 32'h03);
        d = $random(seed);
        ssb_serial_partner_i.send(d, 1'b0, 1'b0, 1'b1); rd(`SSB_OFS_STATUS, 33'hC7);
        rd(`SSB_OFS_RXHOLD, {25'h0, d});
        @(posedge pclk) dma_rx_read <= 1'b1;
        @(posedge pclk) dma_rx_read <= 1'b0;
        d = $random(seed);
        ssb_serial_partner_i.send(d, 1'b0, 1'b1, 1'b1);
        wr(`SSB_OFS_STATUS, 32'hC1);
        ssb_serial_partner_i.send(~d, 1'b0, 1'b0, 1'b0);
        wr(`SSB_OFS_CONTROL, 32'h02);
        rd(`SSB_OFS_STATUS, 33'h8F);
        rd(`SSB_OFS_RXHOLD, {25'h0, d});
        @(negedge pclk) check(33'h1, {32'h0, irq});
        @(negedge pclk) check(33'h1, {32'h0, rxb});
        wr(`SSB_OFS_MODE, 32'h38);
        @(negedge pclk) check(33'h1, {32'h0, txb});
        wr(`SSB_OFS_MODE, 32'h18); rd(`SSB_OFS_INTSTAT, 33'h05);
        @(negedge pclk) check(33'h0, {32'h0, txb});
        wr(`SSB_OFS_STATUS, 32'hC1); rd(`SSB_OFS_STATUS, 33'h87);
        wr(`SSB_OFS_INTEN, 32'h00);
        @(negedge pclk) check(33'h0, {32'h0, irq});
        wr(`SSB_OFS_INTCLR, 32'h1F); wr(`SSB_OFS_INTEN, 32'h01);
        @(negedge pclk) check(33'h0, {32'h0, irq});
        wr(`SSB_OFS_STATUS, 32'h41); rd(`SSB_OFS_STATUS, 33'h03);
        wr(`SSB_OFS_STATUS, 32'h05); rd(`SSB_OFS_STATUS, 33'h03);
        @(posedge pclk) tx_load <= 1'b1;
        @(posedge pclk) tx_load <= 1'b0;
        @(posedge pclk) tx_last_bit <= 1'b1;
        @(posedge pclk) tx_last_bit <= 1'b0;
        rd(`SSB_OFS_STATUS, 33'h87);
        d = $random(seed);
        @(posedge pclk) begin dma_tx_write <= 1'b1; dma_tx_data <= d; end
        @(posedge pclk) dma_tx_write <= 1'b0;
        @(negedge pclk) check({25'h0, d}, {25'h0, txh});
        rd(`SSB_OFS_STATUS, 33'h03);
        wr(`SSB_OFS_CONTROL, 32'h01); rd(`SSB_OFS_STATUS, 33'h87);
        wr(`SSB_OFS_CONTROL, 32'h03); wr(`SSB_OFS_MODE, 32'h1C);
        d = $random(seed);
        ssb_serial_partner_i.send(d, 1'b1, 1'b0, 1'b0); rd(`SSB_OFS_STATUS, 33'hC5);
        rd(`SSB_OFS_RXHOLD, {25'h0, d});
        @(posedge pclk) tx_busy <= 1'b1;
        @(negedge pclk) check(33'h1, {32'h0, txmpb});
        wr(`SSB_OFS_MODE, 32'h38);
        @(negedge pclk) check(33'h0, {32'h0, txmpb});
        @(posedge pclk) tx_busy <= 1'b0;
        wr(`SSB_OFS_DIVISOR, 32'h01);
        for (int k = 0; k < 4; k++) begin
            wr(`SSB_OFS_MODE, k);
            n = 0;
            do begin @(negedge pclk); n++; end while (tick !== 1'b1 && n < 400);
            if (tick !== 1'b1) begin fails++; finish_test; end
            n = 0;
            do begin @(negedge pclk); n++; end while (tick !== 1'b1 && n < 400);
            if (tick !== 1'b1) begin fails++; finish_test; end
            check(33'd2 << (2 * k), n);
        end
        @(posedge pclk) standby <= 1'b1;
        repeat (2) @(posedge pclk);
        standby <= 1'b0;
        rd(`SSB_OFS_STATUS, 33'h84); rd(`SSB_OFS_DIVISOR, 33'hFF);
        finish_test;
    end
endmodule // ssb_serial_status_tb
`default_nettype wire
